//--- hw/flash_read_cfg.sv
`timescale 1ns/1ps
module flash_read_cfg #(
  parameter int ADDR_W = 24,
  parameter int FIFO_DEPTH = 16,
  parameter bit WORD_ADDR = 1'b1,
  parameter logic [15:0] ID_WORD = 16'h00a5 // Arbitrary identifier value.
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic address_valid_n,
  input wire logic burst_clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic wait_out,
  output logic wait_oe,
  input wire logic [7:0] write_state_machine_flags,
  input wire logic [7:0] write_state_machine_errs,
  output logic array_req,
  output logic [ADDR_W-1:0] array_addr,
  input wire logic array_valid,
  input wire logic [15:0] array_data,
  output logic [15:0] read_config_reg
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] burst_words(input logic [2:0] code);
    unique case (code)
      flash_cfg_pkg::SIZE_4: burst_words = 5'h04;
      flash_cfg_pkg::SIZE_8: burst_words = 5'h08;
      flash_cfg_pkg::SIZE_16: burst_words = 5'h10;
      default: burst_words = 5'h00;
    endcase
  endfunction : burst_words

  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
      input logic [2:0] code, input logic no_wrap);
    logic [ADDR_W-1:0] mask;
    mask = ADDR_W'(burst_words(code)) - ADDR_W'(1);
    if (no_wrap || burst_words(code) == 5'h00)
      next_addr = a + ADDR_W'(1);
    else
      next_addr = (a & ~mask) | ((a + ADDR_W'(1)) & mask);
  endfunction : next_addr

  // ----------------------------------------------------------------
  // Bus sampling and edge detection
  // ----------------------------------------------------------------
  logic clk_prev_q;
  logic we_prev_q;
  logic adv_prev_q;
  logic valid_edge;
  logic cmd_take;
  logic access_start;
  logic bus_active;
  logic [7:0] cmd;
  logic [15:0] cfg_value;

  // Previous pin levels for edge detection.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      clk_prev_q <= 1'b0;
      we_prev_q <= 1'b1;
      adv_prev_q <= 1'b1;
    end
    else
    begin
      clk_prev_q <= burst_clk;
      we_prev_q <= write_en_n;
      adv_prev_q <= address_valid_n;
    end
  end

  // The active burst clock edge is chosen by configuration.
  assign valid_edge = read_config_reg[flash_cfg_pkg::CFG_EDGE] ?
      (burst_clk && !clk_prev_q) : (!burst_clk && clk_prev_q);
  assign cmd_take = !chip_en_n && !write_en_n && we_prev_q;
  assign access_start = !chip_en_n && !address_valid_n && adv_prev_q && write_en_n;
  assign bus_active = !chip_en_n && !out_en_n;
  assign cmd = dq_in[7:0];
  // Word-addressed parts shift the configuration value down one bit.
  assign cfg_value = WORD_ADDR ? addr[16:1] : addr[15:0];

  // ----------------------------------------------------------------
  // Command interface
  // ----------------------------------------------------------------
  logic setup_pending_q;
  logic seq_error;
  flash_cfg_pkg::read_src_t read_src_q;

  assign seq_error = cmd_take && setup_pending_q && cmd != flash_cfg_pkg::CMD_CFG_CONFIRM;

  // Two-cycle configuration write and read source selection.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      setup_pending_q <= 1'b0;
      read_src_q <= flash_cfg_pkg::SRC_ARRAY;
      read_config_reg <= flash_cfg_pkg::CFG_RESET;
    end
    else if (cmd_take)
    begin
      setup_pending_q <= (cmd == flash_cfg_pkg::CMD_CFG_SETUP);
      if (setup_pending_q && cmd == flash_cfg_pkg::CMD_CFG_CONFIRM)
      begin
        read_config_reg <= cfg_value;
        read_src_q <= flash_cfg_pkg::SRC_ARRAY;
      end
      else if (cmd == flash_cfg_pkg::CMD_READ_ID)
        read_src_q <= flash_cfg_pkg::SRC_ID;
      else if (cmd == flash_cfg_pkg::CMD_READ_STATUS)
        read_src_q <= flash_cfg_pkg::SRC_STATUS;
      else if (cmd == flash_cfg_pkg::CMD_READ_ARRAY)
        read_src_q <= flash_cfg_pkg::SRC_ARRAY;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  logic [7:0] sticky_q;
  logic [7:0] device_status_reg;
  logic clear_status;

  // The clear command takes no notice of the programming supply.
  assign clear_status = cmd_take && cmd == flash_cfg_pkg::CMD_CLEAR_STATUS;

  // Sticky error bits; a new error in the clearing cycle survives.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sticky_q <= 8'h00;
    else
      sticky_q <= ((clear_status ? 8'h00 : sticky_q)
          | write_state_machine_errs | (seq_error ? flash_cfg_pkg::STAT_SEQ_ERR : 8'h00))
          & flash_cfg_pkg::STAT_STICKY_MASK;
  end

  // Bits 7, 6, 2 and 0 follow the write state machine directly.
  assign device_status_reg = (write_state_machine_flags & flash_cfg_pkg::STAT_LIVE_MASK)
      | sticky_q;

  // ----------------------------------------------------------------
  // Array prefetch into the word FIFO
  // ----------------------------------------------------------------
  stream_if #(.WIDTH(16)) fill_s ();
  stream_if #(.WIDTH(16)) drain_s ();
  logic fetching_q;
  logic pending_q;
  logic [4:0] fetched_q;
  logic sync_mode;
  logic [2:0] size_code;

  assign sync_mode = !read_config_reg[flash_cfg_pkg::CFG_READ_MODE];
  assign size_code = read_config_reg[flash_cfg_pkg::CFG_SIZE_HI:flash_cfg_pkg::CFG_SIZE_LO];
  assign array_req = fetching_q && !pending_q && fill_s.ready;
  assign fill_s.valid = array_valid && pending_q;
  assign fill_s.data = array_data;

  // Fetch words ahead of the host; a full FIFO holds back requests.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fetching_q <= 1'b0;
      pending_q <= 1'b0;
      fetched_q <= 5'h00;
      array_addr <= '0;
    end
    else if (access_start)
    begin
      fetching_q <= (read_src_q == flash_cfg_pkg::SRC_ARRAY);
      pending_q <= 1'b0;
      fetched_q <= 5'h00;
      array_addr <= addr;
    end
    else
    begin
      if (array_req)
        pending_q <= 1'b1;
      else if (fill_s.valid)
        pending_q <= 1'b0;
      if (fill_s.valid)
      begin
        fetched_q <= fetched_q + 5'h01;
        array_addr <= next_addr(array_addr, size_code,
            read_config_reg[flash_cfg_pkg::CFG_WRAP_DIS]);
        // Fixed bursts stop at their length; async reads need one word.
        if (!sync_mode || fetched_q + 5'h01 == burst_words(size_code))
          fetching_q <= 1'b0;
      end
    end
  end

  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(access_start),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // ----------------------------------------------------------------
  // Synchronous burst output sequencing
  // ----------------------------------------------------------------
  flash_cfg_pkg::burst_state_t state_q;
  logic [2:0] lat_cnt_q;
  logic hold_cnt_q;
  logic data_valid_q;
  logic wait_assert_q;
  logic present;
  logic hold_two;
  logic [3:0] lat_next;
  logic [2:0] latency;
  logic early_ok;
  logic wait_assert_d;
  logic async_load;

  assign latency = read_config_reg[flash_cfg_pkg::CFG_LAT_HI:flash_cfg_pkg::CFG_LAT_LO];
  assign hold_two = read_config_reg[flash_cfg_pkg::CFG_HOLD];
  assign lat_next = {1'b0, lat_cnt_q} + 4'h1;
  // A new word goes out when latency expires, then once per data cycle.
  assign present = valid_edge && bus_active
      && ((state_q == flash_cfg_pkg::ST_LAT && lat_next >= {1'b0, latency})
      || (state_q == flash_cfg_pkg::ST_DATA && hold_cnt_q == hold_two));
  assign async_load = !sync_mode && bus_active && !data_valid_q
      && read_src_q == flash_cfg_pkg::SRC_ARRAY;
  assign drain_s.ready = (present || async_load) && drain_s.valid;

  // Latency and data-cycle counters.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= flash_cfg_pkg::ST_IDLE;
      lat_cnt_q <= 3'h0;
      hold_cnt_q <= 1'b0;
    end
    else if (access_start)
    begin
      state_q <= (sync_mode && read_src_q == flash_cfg_pkg::SRC_ARRAY) ?
          flash_cfg_pkg::ST_LAT : flash_cfg_pkg::ST_IDLE;
      lat_cnt_q <= 3'h0;
      hold_cnt_q <= 1'b0;
    end
    else if (!bus_active && address_valid_n)
      state_q <= flash_cfg_pkg::ST_IDLE;
    else if (valid_edge)
    begin
      unique case (state_q)
        flash_cfg_pkg::ST_IDLE: lat_cnt_q <= 3'h0;
        flash_cfg_pkg::ST_LAT:
        begin
          lat_cnt_q <= lat_next[2:0];
          if (present)
            state_q <= flash_cfg_pkg::ST_DATA;
        end
        flash_cfg_pkg::ST_DATA: hold_cnt_q <= present ? 1'b0 : !hold_cnt_q;
      endcase
    end
  end

  // Data register: burst word, async word or non-array contents.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dq_out <= 16'h0000;
      data_valid_q <= 1'b0;
    end
    else if (access_start || !bus_active)
      data_valid_q <= 1'b0;
    else if (read_src_q == flash_cfg_pkg::SRC_STATUS)
      dq_out <= {8'h00, device_status_reg};
    else if (read_src_q == flash_cfg_pkg::SRC_ID)
      dq_out <= (addr[7:0] == flash_cfg_pkg::ID_CFG_OFFSET) ? read_config_reg : ID_WORD;
    else if (present || async_load)
    begin
      data_valid_q <= drain_s.valid;
      if (drain_s.valid)
        dq_out <= drain_s.data;
    end
  end

  assign dq_oe = bus_active;

  // ----------------------------------------------------------------
  // Wait output
  // ----------------------------------------------------------------
  // Early mode releases wait one data cycle ahead when the word is queued.
  assign early_ok = drain_s.valid && (state_q == flash_cfg_pkg::ST_DATA
      || lat_next + {3'h0, hold_two} + 4'h1 >= {1'b0, latency});
  always_comb
  begin
    if (!sync_mode || read_src_q != flash_cfg_pkg::SRC_ARRAY)
      wait_assert_d = 1'b0;
    else if (read_config_reg[flash_cfg_pkg::CFG_WAIT_EARLY])
      wait_assert_d = !early_ok;
    else
      wait_assert_d = !(present ? drain_s.valid : data_valid_q);
  end

  // In synchronous mode wait state moves only on a valid edge of an active bus cycle.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wait_assert_q <= 1'b0;
    else if (!sync_mode)
      wait_assert_q <= 1'b0;
    else if (valid_edge && bus_active)
      wait_assert_q <= wait_assert_d;
  end

  assign wait_out = read_config_reg[flash_cfg_pkg::CFG_WAIT_POL] ?
      wait_assert_q : !wait_assert_q;
  assign wait_oe = bus_active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_cfg_reset_value: assert property ($fell(sys_rst) |->
      read_config_reg == flash_cfg_pkg::CFG_RESET)
    else $error("configuration not at default after reset");

  chk_confirm_loads_cfg: assert property (cmd_take && setup_pending_q
      && cmd == flash_cfg_pkg::CMD_CFG_CONFIRM |=> read_config_reg == $past(cfg_value))
    else $error("confirm did not load configuration");

  chk_seq_error_flag: assert property (seq_error |=>
      (device_status_reg & flash_cfg_pkg::STAT_SEQ_ERR) == flash_cfg_pkg::STAT_SEQ_ERR)
    else $error("sequence error not flagged");

  chk_clear_status_cmd: assert property (clear_status && write_state_machine_errs == 8'h00
      && !seq_error |=> sticky_q == 8'h00)
    else $error("clear status left sticky bits");

  chk_sticky_holds: assert property (!clear_status |=>
      (sticky_q & $past(sticky_q)) == $past(sticky_q))
    else $error("sticky bit dropped without clear");

  chk_id_cfg_read: assert property (bus_active && read_src_q == flash_cfg_pkg::SRC_ID
      && addr[7:0] == flash_cfg_pkg::ID_CFG_OFFSET && !access_start
      |=> dq_out == $past(read_config_reg))
    else $error("identifier offset did not return configuration");

  chk_wait_on_edge: assert property (sync_mode && $past(sync_mode)
      && $changed(wait_assert_q) |-> $past(valid_edge && bus_active))
    else $error("wait changed away from a valid edge");

  chk_wait_polarity: assert property (wait_out ==
      (read_config_reg[flash_cfg_pkg::CFG_WAIT_POL] ~^ wait_assert_q))
    else $error("wait level does not follow polarity");

  chk_async_no_wait: assert property (!sync_mode ##1 !sync_mode |-> !wait_assert_q)
    else $error("wait asserted in asynchronous mode");

endmodule : flash_read_cfg

//--- hw/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic [WIDTH-1:0] head_q;
  logic head_valid_q;
  logic push;
  logic load;

  // Full stalls the filling side; the head register feeds the reader.
  assign in_s.ready = (cnt_q != (AW+1)'(DEPTH)) && !flush;
  assign push = in_s.valid && in_s.ready;
  assign load = (cnt_q != '0) && (!head_valid_q || out_s.ready);
  assign out_s.valid = head_valid_q;
  assign out_s.data = head_q;

  // Storage array, written only.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_q] <= in_s.data;
  end

  // Pointers and fill count.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + AW'(1);
      if (load)
        rd_ptr_q <= rd_ptr_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Registered head word.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || flush)
    begin
      head_valid_q <= 1'b0;
      head_q <= '0;
    end
    else if (load)
    begin
      head_valid_q <= 1'b1;
      head_q <= mem[rd_ptr_q];
    end
    else if (out_s.ready)
      head_valid_q <= 1'b0;
  end

endmodule : word_fifo

//--- inc/flash_cfg_pkg.sv
package flash_cfg_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

  // ----------------------------------------------------------------
  // Read configuration register layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'hbfcf;
  localparam int CFG_READ_MODE = 15;
  localparam int CFG_LAT_HI = 13;
  localparam int CFG_LAT_LO = 11;
  localparam int CFG_WAIT_POL = 10;
  localparam int CFG_HOLD = 9;
  localparam int CFG_WAIT_EARLY = 8;
  localparam int CFG_ORDER = 7;
  localparam int CFG_EDGE = 6;
  localparam int CFG_WRAP_DIS = 3;
  localparam int CFG_SIZE_HI = 2;
  localparam int CFG_SIZE_LO = 0;
  localparam logic [2:0] LAT_MIN = 3'h2;
  localparam logic [2:0] SIZE_4 = 3'h1;
  localparam logic [2:0] SIZE_8 = 3'h2;
  localparam logic [2:0] SIZE_16 = 3'h3;
  localparam logic [2:0] SIZE_CONT = 3'h7;
  localparam logic [7:0] ID_CFG_OFFSET = 8'h05;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_LIVE_MASK = 8'hc5;
  localparam logic [7:0] STAT_STICKY_MASK = 8'h3a;
  localparam logic [7:0] STAT_SEQ_ERR = 8'h30;

  typedef enum logic [1:0] {SRC_ARRAY, SRC_STATUS, SRC_ID} read_src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_DATA} burst_state_t;

endpackage : flash_cfg_pkg

//--- inc/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

//--- test/array_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Array behind the word fetch port
// ----------------------------------------------------------------
module array_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic array_req,
  input wire logic [23:0] array_addr,
  input wire logic [31:0] lag,
  output logic array_valid,
  output logic [15:0] array_data
);
  logic busy_q;
  logic [23:0] addr_q;
  int cnt_q;

  // Takes one request, answers lag plus one cycles after taking it and idles one cycle after the answer.
  // Between answers the data lines keep changing, so a stale word is never mistaken.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      array_valid <= 1'b0;
      array_data <= 16'h0000;
      cnt_q <= 0;
    end
    else if (array_valid)
    begin
      array_valid <= 1'b0;
      busy_q <= 1'b0;
      array_data <= ~array_data;
    end
    else if (busy_q)
    begin
      if (cnt_q == 0)
      begin
        array_valid <= 1'b1;
        array_data <= addr_q[15:0] ^ 16'h3c00;
      end
      else
      begin
        cnt_q <= cnt_q - 1;
        array_data <= ~array_data;
      end
    end
    else
    begin
      array_data <= ~array_data;
      if (array_req)
      begin
        busy_q <= 1'b1;
        addr_q <= array_addr;
        cnt_q <= lag;
      end
    end
  end
endmodule : array_model

//--- test/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the read configuration and status logic
// ----------------------------------------------------------------
module testbench;
  logic clk_sys;
  logic sys_rst;
  logic chip_en_n;
  logic out_en_n;
  logic write_en_n;
  logic address_valid_n;
  logic burst_clk;
  logic [23:0] addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic dq_oe;
  logic wait_out;
  logic wait_oe;
  logic [7:0] flags;
  logic [7:0] errs;
  logic array_req;
  logic [23:0] array_addr;
  logic array_valid;
  logic [15:0] array_data;
  logic [15:0] read_config_reg;
  int lag;
  int n_errors = 0;
  int num_checks = 0;

  // Free running 125 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  flash_read_cfg #(.WORD_ADDR(1'b0)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .address_valid_n(address_valid_n), .burst_clk(burst_clk),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out),
    .wait_oe(wait_oe), .write_state_machine_flags(flags), .write_state_machine_errs(errs),
    .array_req(array_req), .array_addr(array_addr), .array_valid(array_valid),
    .array_data(array_data), .read_config_reg(read_config_reg));

  array_model mem_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .array_req(array_req), .array_addr(array_addr),
    .lag(lag), .array_valid(array_valid), .array_data(array_data));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Writes one command cycle; the design takes it on the first low cycle of write enable.
  task automatic cmd(input logic [7:0] code, input logic [23:0] a);
    chip_en_n = 1'b0;
    write_en_n = 1'b0;
    dq_in = {8'h00, code};
    addr = a;
    tick(1);
    write_en_n = 1'b1;
    chip_en_n = 1'b1;
    tick(1);
  endtask : cmd

  task automatic set_cfg(input logic [23:0] a);
    cmd(flash_cfg_pkg::CMD_CFG_SETUP, 24'h000000);
    cmd(flash_cfg_pkg::CMD_CFG_CONFIRM, a);
  endtask : set_cfg

  // Single read access; waits a bounded time for the word, then checks it and wait.
  task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string what);
    int k;
    chip_en_n = 1'b0;
    out_en_n = 1'b0;
    address_valid_n = 1'b0;
    addr = a;
    tick(1);
    address_valid_n = 1'b1;
    for (k = 0; k < 16 && dq_out !== exp; k++) tick(1);
    check(dq_out, exp, what);
    check({15'h0000, wait_out}, 16'h0000, "wait idle level");
    check({14'h0000, dq_oe, wait_oe}, 16'h0003, "pins driven in bus cycle");
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    tick(1);
  endtask : rd

  // Synchronous burst: one valid burst clock edge every four system clocks.
  task automatic burst(input logic [15:0] cfg, input logic [23:0] start, input int lg);
    int lc;
    int h;
    int len;
    int e;
    int i;
    logic [23:0] w;
    lc = int'(cfg[13:11]);
    h = cfg[9] ? 2 : 1;
    len = 2 << cfg[2:0];
    lag = lg;
    set_cfg({8'h00, cfg});
    burst_clk = ~cfg[6];
    cmd(flash_cfg_pkg::CMD_READ_ARRAY, 24'h000000);
    chip_en_n = 1'b0;
    out_en_n = 1'b0;
    address_valid_n = 1'b0;
    addr = start;
    tick(1);
    address_valid_n = 1'b1;
    tick(1);
    for (e = 1; e < lc + 4 * h; e++)
    begin
      burst_clk = cfg[6];
      tick(2);
      burst_clk = ~cfg[6];
      tick(2);
      if (e == 1) check({15'h0000, wait_out}, {15'h0000, cfg[10]}, "wait asserted");
      if (e == lc - 1) check({15'h0000, wait_out}, {15'h0000, cfg[8] ^ cfg[10]}, "wait early");
      if (e >= lc)
      begin
        i = (e - lc) / h;
        if (cfg[3]) w = start + 24'(i);
        else w = (start & ~24'(len - 1)) | ((start + 24'(i)) & 24'(len - 1));
        check(dq_out, w[15:0] ^ 16'h3c00, "burst word");
        check({15'h0000, wait_out}, {15'h0000, ~cfg[10]}, "wait released");
      end
    end
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    tick(1);
  endtask : burst

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  // Cuts a hung run short.
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    n_errors++;
    $display("BAD t=%0t run did not finish", $time);
    complete_run();
  end

  // Host side: every command and read; sticky bits are cleared once by the clear command and once by a second reset.
  initial
  begin
    sys_rst = 1'b1;
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    write_en_n = 1'b1;
    address_valid_n = 1'b1;
    burst_clk = 1'b0;
    addr = 24'h000000;
    dq_in = 16'h0000;
    flags = 8'h80;
    errs = 8'h00;
    lag = 1;
    tick(4);
    sys_rst = 1'b0;
    check(read_config_reg, 16'hbfcf, "config after reset");
    cmd(flash_cfg_pkg::CMD_READ_STATUS, 24'h000000);
    rd(24'h000000, 16'h0080, "status after reset");
    cmd(flash_cfg_pkg::CMD_READ_ARRAY, 24'h000000);
    rd(24'h000123, 16'h0123 ^ 16'h3c00, "async array word");
    $display("test defaults done");
    cmd(flash_cfg_pkg::CMD_CFG_CONFIRM, 24'h001cc1);
    check(read_config_reg, 16'hbfcf, "lone confirm");
    set_cfg(24'h011cc1);
    check(read_config_reg, 16'h1cc1, "config written");
    cmd(flash_cfg_pkg::CMD_READ_ID, 24'h000000);
    rd(24'h000005, 16'h1cc1, "config via identifier");
    $display("test config_write done");
    cmd(flash_cfg_pkg::CMD_CFG_SETUP, 24'h000000);
    cmd(flash_cfg_pkg::CMD_READ_STATUS, 24'h000000);
    check(read_config_reg, 16'h1cc1, "config kept");
    cmd(flash_cfg_pkg::CMD_READ_STATUS, 24'h000000);
    rd(24'h000000, 16'h00b0, "sequence error");
    errs = 8'h0a;
    tick(1);
    errs = 8'h00;
    flags = 8'h45;
    rd(24'h000000, 16'h007f, "sticky and live bits");
    flags = 8'h80;
    cmd(flash_cfg_pkg::CMD_CLEAR_STATUS, 24'h000000);
    cmd(flash_cfg_pkg::CMD_READ_STATUS, 24'h000000);
    rd(24'h000000, 16'h0080, "clear status");
    errs = 8'h20;
    tick(1);
    errs = 8'h00;
    sys_rst = 1'b1;
    tick(1);
    sys_rst = 1'b0;
    check(read_config_reg, 16'hbfcf, "config after second reset");
    cmd(flash_cfg_pkg::CMD_READ_STATUS, 24'h000000);
    rd(24'h000000, 16'h0080, "reset clears status");
    $display("test status done");
    burst(16'h1cc1, 24'h000102, 1);
    burst(16'h238a, 24'h000206, 3);
    $display("test bursts done");
    complete_run();
  end
endmodule : testbench
